// ### core/eirq_regs.sv
// Functional notes
// RULE_01 - pull-up disable bit turns all pull-ups off
// RULE_02 - edge select bits: 1 rising, 0 falling
// RULE_03 - timer0, ext3, port-change priority bits
// RULE_04 - ext2 and ext1 priority bits
// RULE_05 - ext3..ext1 enable bits permit interrupts
// RULE_06 - ext flags set on edge, sticky
// RULE_07 - flags set regardless of any enable
// RULE_08 - software clears flags before enabling
// RULE_09 - six peripheral flag registers exist
// RULE_10 - parallel port flag set on transfer
// RULE_11 - adc done flag set on conversion
// RULE_12 - rx full bit mirrors receiver, read-only
// RULE_13 - tx empty bit mirrors transmitter, read-only
// RULE_14 - sync serial flags set on completion
// RULE_15 - timer gate flags set on gate event
// RULE_16 - timer2 match flag set on match
// RULE_17 - timer overflow flags set on overflow
// RULE_18 - oscillator fail flag set on failover
// RULE_19 - bus collision flags set on collision
// RULE_20 - voltage detect flag set on low voltage
// RULE_21 - unimplemented bits read as zero
// RULE_22 - priority bits ignored in compatibility mode
// RULE_23 - flag, enable, global enable vector request
// RULE_24 - high vector 0008h, low vector 0018h
// RULE_25 - software write sets or clears flags
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "eirq_defines.svh"

module eirq_regs (
  // clock, reset, enable
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // register port
  input  wire eirq_pkg::eirq_addr_t addr_i,
  input  wire eirq_pkg::eirq_byte_t wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output      eirq_pkg::eirq_byte_t rdata_o,
  // external interrupt pins 3..1
  input  wire logic [3:1]          ext_pin_i,
  // peripheral events, one-cycle pulses
  input  wire logic                psp_done_i,
  input  wire logic                adc_done_i,
  input  wire logic                ssp1_done_i,
  input  wire logic                tmr1_gate_i,
  input  wire logic                tmr2_match_i,
  input  wire logic                tmr1_ovf_i,
  input  wire logic                osc_fail_i,
  input  wire logic                ssp2_done_i,
  input  wire logic                bcl2_i,
  input  wire logic                bcl1_i,
  input  wire logic                hlvd_i,
  input  wire logic                tmr3_ovf_i,
  input  wire logic                tmr3_gate_i,
  // serial port 1 buffer levels
  input  wire logic                uart1_rx_full_i,
  input  wire logic                uart1_tx_empty_i,
  // enables and priorities held elsewhere
  input  wire eirq_pkg::eirq_byte_t periph_enable_one_i,
  input  wire eirq_pkg::eirq_byte_t periph_enable_two_i,
  input  wire eirq_pkg::eirq_byte_t periph_prio_one_i,
  input  wire eirq_pkg::eirq_byte_t periph_prio_two_i,
  input  wire logic                priority_mode_enable_i,
  input  wire logic                global_irq_enable_i,
  input  wire logic                periph_irq_enable_i,
  // control outputs
  output logic                     portb_pullup_disable_o,
  output logic                     ext0_edge_select_o,
  output logic                     timer0_ovf_priority_o,
  output logic                     port_change_priority_o,
  // vector request
  output logic                     irq_req_o,
  output      eirq_pkg::eirq_vec_t irq_vector_o
);

  // ==========================================================
  // state
  eirq_pkg::eirq_byte_t ctrl2_q;
  eirq_pkg::eirq_byte_t ctrl3_q;
  eirq_pkg::eirq_byte_t ctrl3_d;
  eirq_pkg::eirq_byte_t pflag1_q;
  eirq_pkg::eirq_byte_t pflag1_d;
  eirq_pkg::eirq_byte_t pflag2_q;
  eirq_pkg::eirq_byte_t pflag2_d;
  eirq_pkg::eirq_byte_t rdata_q;
  eirq_pkg::eirq_byte_t rdata_d;
  eirq_pkg::eirq_vec_t  vec_q;
  eirq_pkg::eirq_vec_t  vec_d;
  logic                 req_q;
  logic                 req_d;
  logic [3:1]           pin_q;
  logic [3:1]           edge_sel;
  logic [3:1]           ext_evt;
  eirq_pkg::eirq_byte_t ev1;
  eirq_pkg::eirq_byte_t ev2;
  logic                 wr2;
  logic                 wr3;
  logic                 wrp1;
  logic                 wrp2;

  assign wr2  = wr_i && (addr_i == `EIRQ_OFS_EDGE_PRIO);
  assign wr3  = wr_i && (addr_i == `EIRQ_OFS_ENA_FLAG);
  assign wrp1 = wr_i && (addr_i == `EIRQ_OFS_PERIPH_ONE);
  assign wrp2 = wr_i && (addr_i == `EIRQ_OFS_PERIPH_TWO);

  // ==========================================================
  // edge/priority control register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl2_q <= `EIRQ_RST_EDGE_PRIO;
    end else if (ce_i && wr2) begin
      ctrl2_q <= wdata_i; // [RULE_01] [RULE_02] [RULE_03]
    end
  end

  // ==========================================================
  // external pin edge detection
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q <= 3'h0;
    end else if (ce_i) begin
      pin_q <= ext_pin_i;
    end
  end

  assign edge_sel = {ctrl2_q[`EIRQ_POS_EDG3], ctrl2_q[`EIRQ_POS_EDG2],
                     ctrl2_q[`EIRQ_POS_EDG1]};

  // pins are synchronous; a select change alone cannot fake an edge
  assign ext_evt = (edge_sel & ext_pin_i & ~pin_q)
                 | (~edge_sel & ~ext_pin_i & pin_q); // [RULE_02]

  // ==========================================================
  // enable/flag control register
  always_comb begin
    ctrl3_d = wr3 ? wdata_i : ctrl3_q; // [RULE_04] [RULE_05] [RULE_25]
    // set beats a same-cycle clear
    ctrl3_d[`EIRQ_POS_EXT3_FLAG:`EIRQ_POS_EXT1_FLAG] =
      ctrl3_d[`EIRQ_POS_EXT3_FLAG:`EIRQ_POS_EXT1_FLAG] | ext_evt; // [RULE_06] [RULE_07]
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl3_q <= `EIRQ_RST_ENA_FLAG;
    end else if (ce_i) begin
      ctrl3_q <= ctrl3_d;
    end
  end

  // ==========================================================
  // peripheral flag registers one and two
  // registers three to six live with their own sources [RULE_09]
  assign ev1 = {psp_done_i, adc_done_i, 2'b00, ssp1_done_i,
                tmr1_gate_i, tmr2_match_i, tmr1_ovf_i};
  assign ev2 = {osc_fail_i, 1'b0, ssp2_done_i, bcl2_i,
                bcl1_i, hlvd_i, tmr3_ovf_i, tmr3_gate_i};

  always_comb begin
    pflag1_d = ((wrp1 ? wdata_i : pflag1_q) & `EIRQ_WMASK_ONE) // [RULE_10] [RULE_11] [RULE_14]
             | ev1; // [RULE_15] [RULE_16] [RULE_17] [RULE_25]
    pflag1_d[`EIRQ_POS_RX_FULL]  = uart1_rx_full_i;  // [RULE_12]
    pflag1_d[`EIRQ_POS_TX_EMPTY] = uart1_tx_empty_i; // [RULE_13]
  end

  always_comb begin
    pflag2_d = ((wrp2 ? wdata_i : pflag2_q) | ev2) // [RULE_14] [RULE_15] [RULE_17] [RULE_18]
             & `EIRQ_WMASK_TWO; // [RULE_19] [RULE_20] [RULE_21]
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pflag1_q <= `EIRQ_RST_PERIPH;
    end else if (ce_i) begin
      pflag1_q <= pflag1_d;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pflag2_q <= `EIRQ_RST_PERIPH;
    end else if (ce_i) begin
      pflag2_q <= pflag2_d;
    end
  end

  // ==========================================================
  // vector request
  logic [2:0]  ext_pend;
  logic [2:0]  ext_prio;
  logic [15:0] per_pend;
  logic [15:0] per_prio;
  logic        hi_req;
  logic        lo_req;

  assign ext_pend = ctrl3_q[`EIRQ_POS_EXT3_FLAG:`EIRQ_POS_EXT1_FLAG]
                  & ctrl3_q[`EIRQ_POS_EXT3_EN:`EIRQ_POS_EXT1_EN]; // [RULE_05]
  assign ext_prio = {ctrl2_q[`EIRQ_POS_EXT3_PRIO], ctrl3_q[`EIRQ_POS_EXT2_PRIO],
                     ctrl3_q[`EIRQ_POS_EXT1_PRIO]}; // [RULE_03] [RULE_04]
  assign per_pend = {pflag2_q & periph_enable_two_i, pflag1_q & periph_enable_one_i};
  assign per_prio = {periph_prio_two_i, periph_prio_one_i};

  // low priority needs both global enables
  assign hi_req = global_irq_enable_i
                && ((|(ext_pend & ext_prio)) || (|(per_pend & per_prio)));
  assign lo_req = global_irq_enable_i && periph_irq_enable_i
                && ((|(ext_pend & ~ext_prio)) || (|(per_pend & ~per_prio)));

  always_comb begin
    if (priority_mode_enable_i) begin
      req_d = hi_req || lo_req; // [RULE_23]
      vec_d = hi_req ? `EIRQ_VEC_HIGH : `EIRQ_VEC_LOW; // [RULE_24]
    end else begin
      // compatibility mode: priorities ignored, one vector
      req_d = global_irq_enable_i
            && ((|ext_pend) || (periph_irq_enable_i && (|per_pend))); // [RULE_22] [RULE_23]
      vec_d = `EIRQ_VEC_HIGH; // [RULE_22]
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      vec_q <= `EIRQ_VEC_HIGH;
    end else if (ce_i) begin
      req_q <= req_d;
      vec_q <= vec_d;
    end
  end

  // ==========================================================
  // read port
  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        `EIRQ_OFS_EDGE_PRIO:  rdata_d = ctrl2_q;
        `EIRQ_OFS_ENA_FLAG:   rdata_d = ctrl3_q;
        `EIRQ_OFS_PERIPH_ONE: rdata_d = pflag1_q;
        `EIRQ_OFS_PERIPH_TWO: rdata_d = pflag2_q; // [RULE_21]
      endcase
    end
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // outputs
  assign rdata_o                = rdata_q;
  assign portb_pullup_disable_o = ctrl2_q[`EIRQ_POS_PULLUP_DIS]; // [RULE_01]
  assign ext0_edge_select_o     = ctrl2_q[`EIRQ_POS_EDG0];
  assign timer0_ovf_priority_o  = ctrl2_q[`EIRQ_POS_TMR0_PRIO];
  assign port_change_priority_o = ctrl2_q[`EIRQ_POS_PCHG_PRIO];
  assign irq_req_o              = req_q;
  assign irq_vector_o           = vec_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_PULLUP_WRITE: assert property ( // [RULE_01]
    ce_i && wr2 |=> portb_pullup_disable_o == $past(wdata_i[7]))
    else $error("pull-up disable not taken from write");

  AST_EXT1_RISE: assert property ( // [RULE_02]
    ce_i && ctrl2_q[`EIRQ_POS_EDG1] && ext_pin_i[1] && !pin_q[1]
    |=> ctrl3_q[`EIRQ_POS_EXT1_FLAG])
    else $error("rising edge did not set ext1 flag");

  AST_EXT2_FALL: assert property ( // [RULE_02]
    ce_i && !ctrl2_q[`EIRQ_POS_EDG2] && !ext_pin_i[2] && pin_q[2]
    |=> ctrl3_q[1])
    else $error("falling edge did not set ext2 flag");

  AST_EXT_NO_WRONG_EDGE: assert property ( // [RULE_06]
    ce_i && !wr3 && !ctrl3_q[0] && ctrl2_q[`EIRQ_POS_EDG1]
    && !ext_pin_i[1] && pin_q[1] |=> !ctrl3_q[0])
    else $error("ext1 flag set on unselected edge");

  AST_FLAG_STICKY: assert property ( // [RULE_06]
    ce_i && ctrl3_q[2] && !wr3 |=> ctrl3_q[2])
    else $error("ext3 flag dropped without software");

  AST_POLL_ADC: assert property ( // [RULE_07]
    ce_i && adc_done_i && !periph_enable_one_i[6] && !global_irq_enable_i
    |=> pflag1_q[6] && !irq_req_o)
    else $error("adc flag depends on enables");

  AST_SET_WINS: assert property ( // [RULE_20]
    ce_i && wrp2 && !wdata_i[2] && hlvd_i |=> pflag2_q[2])
    else $error("clear won over voltage event");

  AST_RX_MIRROR: assert property ( // [RULE_12]
    ce_i && wrp1 |=> pflag1_q[5] == $past(uart1_rx_full_i))
    else $error("rx full bit took written value");

  AST_UNIMP_ZERO: assert property ( // [RULE_21]
    rd_i && ce_i && addr_i == `EIRQ_OFS_PERIPH_TWO |=> !rdata_o[6])
    else $error("unimplemented bit read as one");

  AST_COMPAT_VEC: assert property ( // [RULE_22]
    ce_i && !priority_mode_enable_i |=> irq_vector_o == `EIRQ_VEC_HIGH)
    else $error("compatibility mode used low vector");

  AST_EXT1_HIGH_REQ: assert property ( // [RULE_23]
    ce_i && priority_mode_enable_i && global_irq_enable_i
    && ctrl3_q[0] && ctrl3_q[3] && ctrl3_q[6]
    |=> irq_req_o && irq_vector_o == `EIRQ_VEC_HIGH)
    else $error("high ext1 request missing");

  AST_LOW_VEC: assert property ( // [RULE_24]
    ce_i && priority_mode_enable_i && !hi_req && lo_req
    |=> irq_req_o && irq_vector_o == `EIRQ_VEC_LOW)
    else $error("low request not at low vector");

  AST_SW_SET: assert property ( // [RULE_25]
    ce_i && wrp1 && wdata_i[0] |=> pflag1_q[0])
    else $error("software set of timer1 flag lost");

  AST_PRIO_WRITE: assert property ( // [RULE_03]
    ce_i && wr2 |=> timer0_ovf_priority_o == $past(wdata_i[2])
    && port_change_priority_o == $past(wdata_i[0]))
    else $error("priority bits not taken from write");

  AST_EXT_PRIO_WRITE: assert property ( // [RULE_04]
    ce_i && wr3 |=> ctrl3_q[7:6] == $past(wdata_i[7:6]))
    else $error("ext priority bits not taken from write");

  AST_EXT_MASKED: assert property ( // [RULE_05]
    ce_i && ctrl3_q[5:3] == 3'h0 && per_pend == 16'h0000 |=> !irq_req_o)
    else $error("request raised with every source masked");

  AST_PSP_FLAG: assert property ( // [RULE_10]
    ce_i && psp_done_i |=> pflag1_q[7])
    else $error("parallel port event did not set its flag");

  AST_TX_MIRROR: assert property ( // [RULE_13]
    ce_i |=> pflag1_q[4] == $past(uart1_tx_empty_i))
    else $error("tx empty bit does not follow transmitter");

  AST_SSP2_FLAG: assert property ( // [RULE_14]
    ce_i && ssp2_done_i |=> pflag2_q[5])
    else $error("sync serial 2 event did not set its flag");

  AST_GATE_STICKY: assert property ( // [RULE_15]
    ce_i && pflag2_q[0] && !wrp2 |=> pflag2_q[0])
    else $error("timer3 gate flag dropped without software");

  AST_TMR2_FLAG: assert property ( // [RULE_16]
    ce_i && tmr2_match_i |=> pflag1_q[1])
    else $error("timer2 match did not set its flag");

  AST_OSC_FLAG: assert property ( // [RULE_18]
    ce_i && osc_fail_i |=> pflag2_q[7])
    else $error("oscillator failure did not set its flag");

  AST_FREEZE: assert property (
    !ce_i |=> $stable(ctrl2_q) && $stable(ctrl3_q) && $stable(pflag1_q)
    && $stable(pflag2_q) && $stable(rdata_o) && $stable(irq_req_o))
    else $error("state moved while clock enable low");

  AST_RDATA_IDLE: assert property (
    ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data stands without a read");

  COV_EXT_REQ: cover property (ce_i && ext_evt[3] ##1 ctrl3_q[2]);
  COV_LOW_REQ: cover property (irq_req_o && irq_vector_o == `EIRQ_VEC_LOW);
  COV_SET_CLEAR: cover property (ce_i && wrp2 && !wdata_i[7] && osc_fail_i);
  COV_READ: cover property (rd_i && ce_i ##1 rdata_o != 8'h00);

endmodule : eirq_regs

// ### pkg/eirq_defines.svh
`ifndef EIRQ_DEFINES_SVH
`define EIRQ_DEFINES_SVH

// ==========================================================
// register offsets
`define EIRQ_OFS_EDGE_PRIO   2'h0
`define EIRQ_OFS_ENA_FLAG    2'h1
`define EIRQ_OFS_PERIPH_ONE  2'h2
`define EIRQ_OFS_PERIPH_TWO  2'h3

// ==========================================================
// edge/priority control fields
`define EIRQ_POS_PULLUP_DIS  7
`define EIRQ_POS_EDG0        6
`define EIRQ_POS_EDG1        5
`define EIRQ_POS_EDG2        4
`define EIRQ_POS_EDG3        3
`define EIRQ_POS_TMR0_PRIO   2
`define EIRQ_POS_EXT3_PRIO   1
`define EIRQ_POS_PCHG_PRIO   0

// ==========================================================
// enable/flag control fields
`define EIRQ_POS_EXT2_PRIO   7
`define EIRQ_POS_EXT1_PRIO   6
`define EIRQ_POS_EXT3_EN     5
`define EIRQ_POS_EXT1_EN     3
`define EIRQ_POS_EXT3_FLAG   2
`define EIRQ_POS_EXT1_FLAG   0

// ==========================================================
// reset values, write masks and mirror bit positions
`define EIRQ_RST_EDGE_PRIO   8'hFF
`define EIRQ_RST_ENA_FLAG    8'hC0
`define EIRQ_RST_PERIPH      8'h00
`define EIRQ_WMASK_ONE       8'hCF
`define EIRQ_WMASK_TWO       8'hBF
`define EIRQ_POS_RX_FULL     5
`define EIRQ_POS_TX_EMPTY    4

// ==========================================================
// vectors
`define EIRQ_VEC_HIGH        16'h0008
`define EIRQ_VEC_LOW         16'h0018

`endif

// ### pkg/eirq_pkg.sv
package eirq_pkg;

  // ==========================================================
  // shared types
  typedef logic [1:0]  eirq_addr_t;
  typedef logic [7:0]  eirq_byte_t;
  typedef logic [15:0] eirq_vec_t;

endpackage : eirq_pkg

// ### tb/eirq_regs_tb.sv
`timescale 1ns/1ps

// ==========================================================
// compare helper
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module eirq_regs_tb;
  logic                 mclk_i, rst_i, ce_i, wr_i, rd_i;
  eirq_pkg::eirq_addr_t addr_i;
  eirq_pkg::eirq_byte_t wdata_i, rdata_o, en1, en2, pr1, pr2, rv;
  logic [3:1]           pins;
  logic [12:0]          fire, ev;
  logic                 slow, rxf, txe, pmode, global_irq_enable, peie;
  logic                 pud, edg0, t0p, pcp, irq;
  eirq_pkg::eirq_vec_t  vec;
  int                   mismatches, comparisons, cyc;
  // bit position of each event in its flag register
  logic [2:0] evb [13] = '{3'h7, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0, 3'h7, 3'h5, 3'h4, 3'h3,
                           3'h2, 3'h1, 3'h0};

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  eirq_src_model u_src (.mclk_i(mclk_i), .rst_i(rst_i), .fire_i(fire), .slow_i(slow),
    .ev_o(ev));

  eirq_regs u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_pin_i(pins),
    .psp_done_i(ev[0]), .adc_done_i(ev[1]), .ssp1_done_i(ev[2]), .tmr1_gate_i(ev[3]),
    .tmr2_match_i(ev[4]), .tmr1_ovf_i(ev[5]), .osc_fail_i(ev[6]), .ssp2_done_i(ev[7]),
    .bcl2_i(ev[8]), .bcl1_i(ev[9]), .hlvd_i(ev[10]), .tmr3_ovf_i(ev[11]),
    .tmr3_gate_i(ev[12]), .uart1_rx_full_i(rxf), .uart1_tx_empty_i(txe),
    .periph_enable_one_i(en1), .periph_enable_two_i(en2), .periph_prio_one_i(pr1),
    .periph_prio_two_i(pr2), .priority_mode_enable_i(pmode), .global_irq_enable_i(global_irq_enable),
    .periph_irq_enable_i(peie), .portb_pullup_disable_o(pud), .ext0_edge_select_o(edg0),
    .timer0_ovf_priority_o(t0p), .port_change_priority_o(pcp), .irq_req_o(irq),
    .irq_vector_o(vec));

  // ==========================================================
  // bus and wait tasks
  task automatic wr(input eirq_pkg::eirq_addr_t a, input eirq_pkg::eirq_byte_t d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input eirq_pkg::eirq_addr_t a, input eirq_pkg::eirq_byte_t e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(negedge mclk_i);
    `CHK(rdata_o, e)
  endtask : rd

  task automatic wt();
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : wt

  // ==========================================================
  // scenarios
  task automatic t_reset();
    `CHK({pud, edg0, t0p, pcp}, 4'hF)
    rd(2'h0, 8'hFF);
    rd(2'h1, 8'hC0);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
  endtask : t_reset

  task automatic t_ext();
    wr(2'h0, 8'h28);
    wr(2'h1, 8'h00);
    wt();
    `CHK({pud, edg0, t0p, pcp}, 4'h0)
    rd(2'h0, 8'h28);
    @(posedge mclk_i);
    pins <= 3'h7;
    wt();
    rd(2'h1, 8'h05);
    wr(2'h1, 8'h00);
    pins <= 3'h0;
    wt();
    rd(2'h1, 8'h02);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(2'h1, 8'hFF);
    ce_i <= 1'b1;
    rd(2'h1, 8'h02);
  endtask : t_ext

  task automatic t_periph();
    for (int i = 0; i < 13; i++) begin
      @(posedge mclk_i);
      slow <= i[0];
      fire <= 13'h0001 << i;
      @(posedge mclk_i);
      fire <= 13'h0000;
      wt();
      rd({1'b1, i >= 6}, 8'h01 << evb[i]);
      rd({1'b1, i >= 6}, 8'h01 << evb[i]);
      wr({1'b1, i >= 6}, 8'h00);
    end
  endtask : t_periph

  task automatic t_mirror();
    rxf <= 1'b1;
    txe <= 1'b1;
    wr(2'h2, 8'h00);
    wt();
    rd(2'h2, 8'h30);
    @(posedge mclk_i);
    rxf <= 1'b0;
    txe <= 1'b0;
    wr(2'h2, 8'hFF);
    wt();
    rd(2'h2, 8'hCF);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'hBF);
    wr(2'h2, 8'h00);
    wr(2'h3, 8'h00);
  endtask : t_mirror

  task automatic t_irq();
    wr(2'h1, 8'h00);
    global_irq_enable <= 1'b1;
    wr(2'h1, 8'h09);
    wt();
    `CHK({irq, vec}, {1'b1, 16'h0008})
    @(posedge mclk_i);
    pmode <= 1'b1;
    peie  <= 1'b1;
    wt();
    `CHK({irq, vec}, {1'b1, 16'h0018})
    @(posedge mclk_i);
    peie <= 1'b0;
    wt();
    `CHK(irq, 1'b0)
    wr(2'h1, 8'h49);
    wt();
    `CHK({irq, vec}, {1'b1, 16'h0008})
    wr(2'h1, 8'h41);
    wt();
    `CHK(irq, 1'b0)
    wr(2'h1, 8'h00);
    pmode <= 1'b0;
    peie  <= 1'b1;
    en1   <= 8'h40;
    wr(2'h2, 8'h40);
    wt();
    `CHK({irq, vec}, {1'b1, 16'h0008})
    @(posedge mclk_i);
    peie <= 1'b0;
    wt();
    `CHK(irq, 1'b0)
    // peripheral priorities in priority mode, register two enables
    @(posedge mclk_i);
    pmode <= 1'b1;
    en2   <= 8'h04;
    pr2   <= 8'h04;
    wr(2'h3, 8'h04);
    wt();
    `CHK({irq, vec}, {1'b1, 16'h0008})
    @(posedge mclk_i);
    pr2 <= 8'h00;
    wt();
    `CHK(irq, 1'b0)
    @(posedge mclk_i);
    peie <= 1'b1;
    wt();
    `CHK({irq, vec}, {1'b1, 16'h0018})
  endtask : t_irq

  // ==========================================================
  // verdict
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    {rst_i, ce_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 1'b1, 2'h0, 2'h0, 8'h00};
    {pins, fire, slow, rxf, txe, pmode, global_irq_enable, peie} = '0;
    {en1, en2, pr1, pr2} = '0;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    t_reset();
    t_ext();
    t_periph();
    t_mirror();
    t_irq();
    end_of_test();
  end
endmodule : eirq_regs_tb

// ### tb/eirq_src_model.sv
`timescale 1ns/1ps

// ==========================================================
// peripheral event sources: one-cycle pulses, prompt or slow
module eirq_src_model (
  // clock, reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // request from bench
  input  wire logic [12:0] fire_i,
  input  wire logic        slow_i,
  // event pulses toward the block
  output logic      [12:0] ev_o
);
  logic [12:0] s1_q;
  logic [12:0] s2_q;

  // slow path adds one stage so flags see late events too
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 13'h0000;
      s2_q <= 13'h0000;
    end else begin
      s1_q <= fire_i;
      s2_q <= s1_q;
    end
  end

  assign ev_o = slow_i ? s2_q : s1_q;
endmodule : eirq_src_model
